/* src/eips_pkg.sv */
/*
  Package for the external interrupt port selector (low half, lines 1 to 3).
  Holds register offset, field positions, reset value, port codes and the
  packed carrier for the per-port pin inputs.
*/
package eips_pkg;

  localparam int unsigned NUM_PORTS    = 6;
  localparam int unsigned PINS_PER_PRT = 16;
  localparam int unsigned CODE_W       = 3;

  // Byte address of the low select register on the bus
  localparam logic [7:0]  SEL_LOW_ADDR = 8'h00;

  // Field positions (low bit) inside the low select register
  localparam int unsigned LINE1_LSB    = 4;
  localparam int unsigned LINE2_LSB    = 8;
  localparam int unsigned LINE3_LSB    = 12;

  localparam logic [2:0]  CODE_RESET   = 3'h0;
  localparam logic [31:0] READ_UNMAPPED = 32'h0000_0000;

  typedef enum logic [2:0] {
    FIRST_PORT  = 3'h0,
    SECOND_PORT = 3'h1,
    THIRD_PORT  = 3'h2,
    FOURTH_PORT = 3'h3,
    FIFTH_PORT  = 3'h4,
    SIXTH_PORT  = 3'h5
  } eips_port_t;

  // Pin levels of all ports, one 16-bit word per port
  typedef struct packed {
    logic [15:0] sixth_port;
    logic [15:0] fifth_port;
    logic [15:0] fourth_port;
    logic [15:0] third_port;
    logic [15:0] second_port;
    logic [15:0] first_port;
  } eips_pins_t;

endpackage

/* src/eips_select_low.sv */
/*
  External interrupt port selector, lines 1 to 3 of the low select register.
  Software writes a 3-bit port code per line over classic Wishbone; each line
  then carries pin n of the chosen port to the edge detectors.
  Assumes port pins are asynchronous to clk_i and are synchronised here.
*/
// The Wishbone interface to the registers and the placing of the registers were decided locally.
`timescale 1ns/10ps
module eips_select_low #(
  parameter int unsigned LINE1_PIN = 1,
  parameter int unsigned LINE2_PIN = 2,
  parameter int unsigned LINE3_PIN = 3
) (
  input  wire logic                clk_i,
  input  wire logic                rst_i,
  input  wire logic                wb_cyc_i,
  input  wire logic                wb_stb_i,
  input  wire logic                wb_we_i,
  input  wire logic [7:0]          wb_adr_i,
  input  wire logic [3:0]          wb_sel_i,
  input  wire logic [31:0]         wb_dat_i,
  output logic      [31:0]         wb_dat_o,
  output logic                     wb_ack_o,
  input  wire eips_pkg::eips_pins_t port_pins_i,
  output logic      [3:1]          ext_irq_line_o
);

  // Per-line port code mux; codes 6 and 7 give zero, a safe quiet level
  function automatic logic pick_pin(input eips_pkg::eips_pins_t pins,
                                    input logic [2:0] code,
                                    input int unsigned pin);
    logic r;
    r = 1'b0;
    case (code)
      eips_pkg::FIRST_PORT:  r = pins.first_port[pin];
      eips_pkg::SECOND_PORT: r = pins.second_port[pin];
      eips_pkg::THIRD_PORT:  r = pins.third_port[pin];
      eips_pkg::FOURTH_PORT: r = pins.fourth_port[pin];
      eips_pkg::FIFTH_PORT:  r = pins.fifth_port[pin];
      eips_pkg::SIXTH_PORT:  r = pins.sixth_port[pin];
      default:               r = 1'b0;
    endcase
    return r;
  endfunction

  // Pulls one 3-bit code field out of a bus word
  function automatic logic [2:0] field_of(input logic [31:0] word,
                                          input int unsigned lsb);
    return word[lsb +: eips_pkg::CODE_W];
  endfunction

  // Each line's pin index must exist inside a port
  if (LINE1_PIN >= eips_pkg::PINS_PER_PRT) begin : g_bad_line1
    $error("line 1 pin index lies outside a port");
  end
  if (LINE2_PIN >= eips_pkg::PINS_PER_PRT) begin : g_bad_line2
    $error("line 2 pin index lies outside a port");
  end
  if (LINE3_PIN >= eips_pkg::PINS_PER_PRT) begin : g_bad_line3
    $error("line 3 pin index lies outside a port");
  end

  logic [2:0]           line1_port_code;
  logic [2:0]           line2_port_code;
  logic [2:0]           line3_port_code;
  logic [2:0]           next_line1_port_code;
  logic [2:0]           next_line2_port_code;
  logic [2:0]           next_line3_port_code;
  logic [31:0]          next_wb_dat_o;
  logic                 next_wb_ack_o;
  eips_pkg::eips_pins_t pins_meta;
  eips_pkg::eips_pins_t pins_sync;
  logic [3:1]           next_ext_irq_line_o;
  logic                 req;
  logic                 hit;
  logic [31:0]          reg_view;

  // Ack low gates the request, so a held strobe is taken every second cycle
  assign req = wb_cyc_i && wb_stb_i && !wb_ack_o;
  assign hit = (wb_adr_i == eips_pkg::SEL_LOW_ADDR);

  // Read view: reserved bits always read zero
  always_comb begin
    reg_view = eips_pkg::READ_UNMAPPED;
    reg_view[eips_pkg::LINE1_LSB +: eips_pkg::CODE_W] = line1_port_code;
    reg_view[eips_pkg::LINE2_LSB +: eips_pkg::CODE_W] = line2_port_code;
    reg_view[eips_pkg::LINE3_LSB +: eips_pkg::CODE_W] = line3_port_code;
  end

  // Pin synchroniser: two flops; no reset, so lines settle from live pins
  always_ff @(posedge clk_i) begin
    pins_meta <= port_pins_i;
    pins_sync <= pins_meta;
  end

  // Code fields: lane 0 holds line 1, lane 1 holds lines 2 and 3
  always_comb begin
    next_line1_port_code = line1_port_code;
    next_line2_port_code = line2_port_code;
    next_line3_port_code = line3_port_code;
    if (req && wb_we_i && hit) begin
      if (wb_sel_i[0]) begin
        next_line1_port_code = field_of(wb_dat_i, eips_pkg::LINE1_LSB);
      end
      if (wb_sel_i[1]) begin
        next_line2_port_code = field_of(wb_dat_i, eips_pkg::LINE2_LSB);
        next_line3_port_code = field_of(wb_dat_i, eips_pkg::LINE3_LSB);
      end
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      line1_port_code <= eips_pkg::CODE_RESET;
      line2_port_code <= eips_pkg::CODE_RESET;
      line3_port_code <= eips_pkg::CODE_RESET;
    end else begin
      line1_port_code <= next_line1_port_code;
      line2_port_code <= next_line2_port_code;
      line3_port_code <= next_line3_port_code;
    end
  end

  // Bus answer: one registered ack per request, unmapped reads give zero
  always_comb begin
    next_wb_ack_o = req;
    next_wb_dat_o = wb_dat_o;
    if (req) begin
      next_wb_dat_o = hit ? reg_view : eips_pkg::READ_UNMAPPED;
    end
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      wb_ack_o <= 1'b0;
      wb_dat_o <= eips_pkg::READ_UNMAPPED;
    end else begin
      wb_ack_o <= next_wb_ack_o;
      wb_dat_o <= next_wb_dat_o;
    end
  end

  // Routing: registered so the edge detectors see glitch-free levels
  always_comb begin
    next_ext_irq_line_o[1] = pick_pin(pins_sync, line1_port_code, LINE1_PIN);
    next_ext_irq_line_o[2] = pick_pin(pins_sync, line2_port_code, LINE2_PIN);
    next_ext_irq_line_o[3] = pick_pin(pins_sync, line3_port_code, LINE3_PIN);
  end

  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ext_irq_line_o <= '0;
    end else begin
      ext_irq_line_o <= next_ext_irq_line_o;
    end
  end

endmodule // eips_select_low

/* test/eips_asserts.sv */
/* Checker bound to the selector ports. Assumes synchronous active-high reset. */
`timescale 1ns/10ps
module eips_asserts (
  input wire logic                 clk_i,
  input wire logic                 rst_i,
  input wire logic                 wb_cyc_i,
  input wire logic                 wb_stb_i,
  input wire logic                 wb_we_i,
  input wire logic [7:0]           wb_adr_i,
  input wire logic [3:0]           wb_sel_i,
  input wire logic [31:0]          wb_dat_i,
  input wire logic [31:0]          wb_dat_o,
  input wire logic                 wb_ack_o,
  input wire eips_pkg::eips_pins_t port_pins_i,
  input wire logic [3:1]           ext_irq_line_o
);
  logic [14:0] r;
  // Shadow of the codes; reserved bits are never stored
  always_ff @(posedge clk_i) begin
    if (rst_i) r <= '0;
    else if (wb_cyc_i && wb_stb_i && !wb_ack_o && wb_we_i && wb_adr_i == 8'h00)
      r <= {wb_sel_i[1] ? {wb_dat_i[14:12], 1'b0, wb_dat_i[10:8]} : r[14:8],
            wb_sel_i[0] ? {1'b0, wb_dat_i[6:4]} : r[7:4], 4'h0};
  end
  default clocking @(posedge clk_i);
  endclocking
  default disable iff (rst_i);
  // Pins and codes settled long enough to pass the synchroniser
  sequence calm;
    $stable(port_pins_i)[*3] ##0 $stable(r) && !$past(rst_i);
  endsequence
  chk_read_back: assert property (wb_ack_o && !$past(wb_we_i) |->
    wb_dat_o == ($past(wb_adr_i) == 8'h00 ? {17'h0, r} : 32'h0)) else $error("bad read");
  chk_line1_route: assert property (calm ##0 r[6:4] < 6 |->
    ext_irq_line_o[1] == port_pins_i[16*r[6:4]+1]) else $error("line 1 wrong");
  chk_line2_route: assert property (calm ##0 r[10:8] < 6 |->
    ext_irq_line_o[2] == port_pins_i[16*r[10:8]+2]) else $error("line 2 wrong");
  chk_line3_route: assert property (calm ##0 r[14:12] < 6 |->
    ext_irq_line_o[3] == port_pins_i[16*r[14:12]+3]) else $error("line 3 wrong");
endmodule // eips_asserts
bind eips_select_low eips_asserts u_chk (.*);

/* test/eips_pins_model.sv */
/* Port pin model. Assumes the bench moves port_i and hot_i after a clock edge. */
`timescale 1ns/10ps
module eips_pins_model (
  input  wire logic [2:0]           port_i,
  input  wire logic                 hot_i,
  output eips_pkg::eips_pins_t      pins_o
);
  // Pins 1 to 3 of the chosen port carry hot_i; pins 1 to 3 of every other port carry its inverse
  always_comb begin
    for (int k = 0; k < 6; k++) pins_o[16*k +: 16] = {16{(k == port_i) != hot_i}} ^ 16'h000e;
  end
endmodule // eips_pins_model

/* test/eips_select_low_tb.sv */
/* Bench: Wishbone tasks, register and routing tests. Assumes the pin model. */
`timescale 1ns/10ps
module eips_select_low_tb;
  logic                 clk_i = 0, rst_i = 1, wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
  logic                 wb_ack_o, hot = 0;
  logic [7:0]           wb_adr_i = 0;
  logic [3:0]           wb_sel_i = 0;
  logic [31:0]          wb_dat_i = 0, wb_dat_o, q;
  logic [2:0]           port = 0, ext_irq_line_o;
  eips_pkg::eips_pins_t port_pins_i;
  int                   error_cnt = 0, checks_done = 0;
  always #25 clk_i = ~clk_i;
  eips_pins_model pm (.port_i(port), .hot_i(hot), .pins_o(port_pins_i));
  eips_select_low uut (.*);
  task automatic cmp(input logic [31:0] got, want);
    checks_done++;
    if (got !== want) begin
      error_cnt++;
      $display("unexpected at %0t: got %h want %h", $time, got, want);
    end
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, input logic [3:0] s);
    @(posedge clk_i);
    {wb_cyc_i, wb_stb_i, wb_we_i, wb_adr_i, wb_sel_i, wb_dat_i} <= {2'h3, w, a, s, d};
    do @(posedge clk_i); while (wb_ack_o !== 1'b1);
    q = wb_dat_o;
    {wb_cyc_i, wb_stb_i} <= 2'h0;
  endtask
  task automatic test_done;
    $display("checks %0d errors %0d", checks_done, error_cnt);
    if (error_cnt == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  initial begin
    repeat (20) @(posedge clk_i);
    rst_i <= 0;
    bus(0, 8'h00, 0, 4'hf);
    cmp(q, 32'h0);
    bus(1, 8'h00, 32'hffff_dddd, 4'hf);
    bus(1, 8'h00, 0, 4'h1);
    bus(0, 8'h00, 0, 4'hf);
    cmp(q, 32'h5500);
    bus(0, 8'h04, 0, 4'hf);
    cmp(q, 32'h0);
    $display("register test done");
    for (int c = 0; c < 6; c++) begin
      bus(1, 8'h00, {17'h0, 3'(c), 1'b0, 3'(c), 1'b0, 3'(c), 4'h0}, 4'hf);
      for (int h = 0; h < 2; h++) begin
        {port, hot} <= {3'(c), h[0]};
        repeat (4) @(posedge clk_i);
        cmp({29'h0, ext_irq_line_o}, {29'h0, {3{h[0]}}});
      end
    end
    $display("routing test done");
    test_done;
  end
  initial begin
    repeat (1000) @(posedge clk_i);
    error_cnt++;
    test_done;
  end
endmodule // eips_select_low_tb
